//--- shared/otg_pkg.sv
package otg_pkg;

    // ==========================================================
    // Register map (byte addresses)
    localparam logic [7:0] ADDR_STATUS  = 8'h00;
    localparam logic [7:0] ADDR_CONTROL = 8'h04;
    localparam logic [7:0] ADDR_POWER   = 8'h08;
    localparam logic [7:0] ADDR_FLAGS   = 8'h0c;

    // ==========================================================
    // Status fields
    localparam int ST_ID      = 7;
    localparam int ST_LSTABLE = 5;
    localparam int ST_SESSION = 3;
    localparam int ST_B_END   = 2;
    localparam int ST_A_VALID = 0;

    // ==========================================================
    // Control fields
    localparam int CT_DP_UP   = 7;
    localparam int CT_DM_UP   = 6;
    localparam int CT_DP_DOWN = 5;
    localparam int CT_DM_DOWN = 4;
    localparam int CT_PWR_ON  = 3;
    localparam int CT_SW_PULL = 2;
    localparam int CT_CHARGE  = 1;
    localparam int CT_DISCHG  = 0;
    localparam logic [7:0] CONTROL_WMASK = 8'hff;

    // ==========================================================
    // Power fields
    localparam int PW_PENDING = 7;
    localparam int PW_GUARD   = 4;
    localparam int PW_BUSY    = 3;
    localparam int PW_SUSPEND = 1;
    localparam int PW_ENABLE  = 0;
    localparam logic [7:0] POWER_WMASK = 8'h13;

    // ==========================================================
    // Change flags (write one to clear)
    localparam int FL_ID      = 7;
    localparam int FL_LINE    = 5;
    localparam int FL_ACT     = 4;
    localparam int FL_SESSION = 3;
    localparam int FL_B_END   = 2;
    localparam int FL_A_VALID = 0;
    localparam logic [7:0] FLAGS_MASK = 8'hbd;

    localparam logic [7:0] RESET_BYTE = 8'h00;

    // Idle pin levels, so that leaving reset raises no false change flag
    localparam logic [6:0] SYNC_IDLE  = 7'h01;
    localparam logic [4:0] PREV_IDLE  = 5'h10;

    // ==========================================================
    // Timing
    localparam int CLK_HZ        = 10_000_000;
    localparam int STABLE_US     = 1000;
    localparam int STABLE_CYCLES = CLK_HZ / 1_000_000 * STABLE_US;
    localparam int CNT_W         = 14;
    localparam int BUSY_CYCLES   = 4;

    // ==========================================================
    // Pull resistor group
    typedef struct packed {
        logic dp_up;
        logic dm_up;
        logic dp_down;
        logic dm_down;
    } pulls_s;

    typedef enum logic [2:0] {
        PWR_OFF  = 3'b001,
        PWR_ON   = 3'b010,
        PWR_WIND = 3'b100
    } pwr_state_e;

endpackage

//--- core/usb_otg_status_power_control.sv
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
// What this block does
// - Status bit 7 shows the synchronised ID pin level.
// - Line-stable bit set only after line state unchanged for 1 ms.
// - Session-valid bit follows the session comparator.
// - B session-end bit follows the B session-end comparator.
// - A supply-valid bit follows the A VBUS-valid comparator.
// - Unimplemented bits read zero and ignore writes.
// - Four pull resistor enable bits, read/write, reset zero.
// - Software pull control selects register bits, else hardware pulls.
// - Supply power output follows its control bit.
// - Charge output follows the charge enable bit.
// - Discharge output follows the discharge enable bit.
// - Activity-pending bit shows detected but unsignalled bus activity.
// - Sleep guard blocks sleep on activity or pending notification.
// - Busy bit high while active or not yet ready to re-enable.
// - Suspend gates the USB clock and lowers transceiver power.
// - Power enable low holds outputs except sleep_block inactive and releases pins.
// - Line change flag set when stable state differs from last.
// - Change flags set by hardware, cleared by writing one.
module usb_otg_status_power_control
    import otg_pkg::*;
(
    // APB
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Pins and comparators
    input  wire logic        id_pin,
    input  wire logic        se0_level,
    input  wire logic        j_level_indicator,
    input  wire logic        session_cmp,
    input  wire logic        b_end_cmp,
    input  wire logic        a_valid_cmp,
    input  wire logic        bus_activity,
    // Module side
    input  wire pulls_s      hw_pulls,
    input  wire logic        module_active,
    input  wire logic        activity_irq_taken,
    // Outputs
    output pulls_s           pulls,
    output logic             supply_power_on,
    output logic             supply_charge_out,
    output logic             supply_discharge_out,
    output logic             usb_clock_gate_n,
    output logic             xcvr_low_power,
    output logic             pins_owned,
    output logic             analog_enable,
    output logic             sleep_block
);

    // ==========================================================
    // Input synchronisers
    localparam int NSYNC = 7;
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] s1_q;
    logic [NSYNC-1:0] s2_q;
    assign raw_in = {bus_activity, a_valid_cmp, b_end_cmp, session_cmp,
                     j_level_indicator, se0_level, id_pin};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= SYNC_IDLE;
            s2_q <= SYNC_IDLE;
        end else begin
            s1_q <= raw_in;
            s2_q <= s1_q;
        end
    end

    logic id_s, se0_s, j_s, ses_s, bend_s, aval_s, act_s;
    assign {act_s, aval_s, bend_s, ses_s, j_s, se0_s, id_s} = s2_q;

    // ==========================================================
    // Registers
    logic [7:0] control_q, control_d;
    logic [7:0] power_q, power_d;
    logic [7:0] flags_q, flags_d;
    logic [1:0] line_q, line_d;
    logic [1:0] stable_line_q, stable_line_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic       stable_q, stable_d;
    logic       pending_q, pending_d;
    logic [4:0] prev_q, prev_d;
    logic [2:0] busy_cnt_q, busy_cnt_d;
    pwr_state_e pstate_q, pstate_d;

    logic wr_en;
    logic [7:0] wbyte;
    assign wr_en = psel && penable && pwrite;
    assign wbyte = pwdata[7:0];

    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = (a == r);
    endfunction

    // ==========================================================
    // Next state
    logic [4:0]  cur_ind;
    logic [1:0]  line_now;
    logic [7:0]  set_ev;
    logic [7:0]  clr_ev;
    assign cur_ind  = {id_s, ses_s, bend_s, aval_s, 1'b0};
    assign line_now = {se0_s, j_s};

    always_comb begin
        control_d     = control_q;
        power_d       = power_q;
        line_d        = line_now;
        stable_line_d = stable_line_q;
        cnt_d         = cnt_q;
        stable_d      = stable_q;
        pending_d     = pending_q;
        prev_d        = cur_ind;
        busy_cnt_d    = busy_cnt_q;
        pstate_d      = pstate_q;
        set_ev        = 8'h00;
        clr_ev        = 8'h00;
        if (wr_en && hit(paddr, ADDR_CONTROL))
            control_d = wbyte & CONTROL_WMASK;
        if (wr_en && hit(paddr, ADDR_POWER))
            power_d = wbyte & POWER_WMASK;
        if (wr_en && hit(paddr, ADDR_FLAGS))
            clr_ev = wbyte & FLAGS_MASK;
        if (line_now != line_q) begin
            cnt_d    = '0;
            stable_d = 1'b0;
        end else if (32'(cnt_q) < STABLE_CYCLES - 1) begin
            cnt_d = cnt_q + CNT_W'(1);
        end else if (!stable_q) begin
            stable_d = 1'b1;
            stable_line_d = line_now;
            if (line_now != stable_line_q)
                set_ev[FL_LINE] = 1'b1;
        end
        set_ev[FL_ID]      = cur_ind[4] ^ prev_q[4];
        set_ev[FL_SESSION] = cur_ind[3] ^ prev_q[3];
        set_ev[FL_B_END]   = cur_ind[2] ^ prev_q[2];
        set_ev[FL_A_VALID] = cur_ind[1] ^ prev_q[1];
        set_ev[FL_ACT]     = act_s;
        // Activity stays pending until the interrupt logic takes it
        if (act_s)
            pending_d = 1'b1;
        else if (activity_irq_taken)
            pending_d = 1'b0;
        case (pstate_q)
            PWR_OFF:  if (power_q[PW_ENABLE]) pstate_d = PWR_ON;
            PWR_ON: begin
                if (!power_q[PW_ENABLE]) begin
                    pstate_d   = PWR_WIND;
                    busy_cnt_d = 3'(BUSY_CYCLES);
                end
            end
            PWR_WIND: begin
                if (busy_cnt_q != 3'h0)
                    busy_cnt_d = busy_cnt_q - 3'h1;
                else if (!module_active)
                    pstate_d = PWR_OFF;
            end
            default: pstate_d = PWR_OFF;
        endcase
        // Set wins over a clear in the same cycle
        flags_d = ((flags_q & ~clr_ev) | set_ev) & FLAGS_MASK;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_q     <= RESET_BYTE;
            power_q       <= RESET_BYTE;
            flags_q       <= RESET_BYTE;
            line_q        <= 2'h0;
            stable_line_q <= 2'h0;
            cnt_q         <= '0;
            stable_q      <= 1'b0;
            pending_q     <= 1'b0;
            prev_q        <= PREV_IDLE;
            busy_cnt_q    <= 3'h0;
            pstate_q      <= PWR_OFF;
        end else begin
            control_q     <= control_d;
            power_q       <= power_d;
            flags_q       <= flags_d;
            line_q        <= line_d;
            stable_line_q <= stable_line_d;
            cnt_q         <= cnt_d;
            stable_q      <= stable_d;
            pending_q     <= pending_d;
            prev_q        <= prev_d;
            busy_cnt_q    <= busy_cnt_d;
            pstate_q      <= pstate_d;
        end
    end

    // ==========================================================
    // Readback
    logic       busy;
    logic       en;
    logic [7:0] status_byte;
    logic [7:0] power_byte;
    assign busy = (pstate_q != PWR_OFF) || module_active;
    assign en   = power_q[PW_ENABLE];

    always_comb begin
        status_byte = 8'h00;
        status_byte[ST_ID]      = id_s;
        status_byte[ST_LSTABLE] = stable_q;
        status_byte[ST_SESSION] = ses_s;
        status_byte[ST_B_END]   = bend_s;
        status_byte[ST_A_VALID] = aval_s;
        power_byte = power_q & POWER_WMASK;
        power_byte[PW_PENDING] = pending_q;
        power_byte[PW_BUSY]    = busy;
        prdata = 32'h0000_0000;
        if (psel && !pwrite) begin
            case (paddr)
                ADDR_STATUS:  prdata = {24'h0, status_byte};
                ADDR_CONTROL: prdata = {24'h0, control_q};
                ADDR_POWER:   prdata = {24'h0, power_byte};
                ADDR_FLAGS:   prdata = {24'h0, flags_q};
                default:      prdata = 32'h0000_0000;
            endcase
        end
    end

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !(hit(paddr, ADDR_STATUS) ||
                     hit(paddr, ADDR_CONTROL) || hit(paddr, ADDR_POWER) ||
                     hit(paddr, ADDR_FLAGS));

    // ==========================================================
    // Outputs
    pulls_s sw_pulls;
    assign sw_pulls = control_q[CT_DP_UP:CT_DM_DOWN];
    assign pulls = !en ? pulls_s'(4'h0) :
                   control_q[CT_SW_PULL] ? sw_pulls : hw_pulls;
    assign supply_power_on      = en && control_q[CT_PWR_ON];
    assign supply_charge_out    = en && control_q[CT_CHARGE];
    assign supply_discharge_out = en && control_q[CT_DISCHG];
    assign usb_clock_gate_n     = en && !power_q[PW_SUSPEND];
    assign xcvr_low_power       = !en || power_q[PW_SUSPEND];
    assign pins_owned           = en;
    assign analog_enable        = en;
    assign sleep_block = power_q[PW_GUARD] && (act_s || pending_q);

    // ==========================================================
    // Checks
    property p_stable_needs_window;
        @(posedge pclk) disable iff (!presetn)
        $rose(stable_q) |-> $past(line_q) == line_q && 32'(cnt_q) == STABLE_CYCLES - 1;
    endproperty
    a_stable_needs_window: assert property (p_stable_needs_window)
        else $error("line stable set without a full window");

    property p_change_restarts;
        @(posedge pclk) disable iff (!presetn)
        (line_now != line_q) |=> (cnt_q == '0 && !stable_q);
    endproperty
    a_change_restarts: assert property (p_change_restarts)
        else $error("line change did not restart the counter");

    property p_id_status;
        @(posedge pclk) disable iff (!presetn)
        $changed(id_pin) |-> ##2 (status_byte[ST_ID] == $past(id_pin, 2));
    endproperty
    a_id_status: assert property (p_id_status)
        else $error("id status does not follow pin");

    property p_flag_set_wins;
        @(posedge pclk) disable iff (!presetn)
        set_ev[FL_ID] |=> flags_q[FL_ID];
    endproperty
    a_flag_set_wins: assert property (p_flag_set_wins)
        else $error("id change flag lost");

    property p_flag_w1c;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && hit(paddr, ADDR_FLAGS) && wbyte[FL_LINE] && !set_ev[FL_LINE])
            |=> !flags_q[FL_LINE];
    endproperty
    a_flag_w1c: assert property (p_flag_w1c)
        else $error("line flag not cleared by write one");

    property p_line_flag;
        @(posedge pclk) disable iff (!presetn)
        $rose(stable_q) && (stable_line_q != $past(stable_line_q)) |-> flags_q[FL_LINE];
    endproperty
    a_line_flag: assert property (p_line_flag)
        else $error("line change flag missing");

    property p_power_off_quiet;
        @(posedge pclk) disable iff (!presetn)
        !en |-> (pulls == 4'h0 && !supply_power_on && !pins_owned && !supply_charge_out);
    endproperty
    a_power_off_quiet: assert property (p_power_off_quiet)
        else $error("outputs active while disabled");

    property p_disable_busy;
        @(posedge pclk) disable iff (!presetn)
        (pstate_q == PWR_ON && !en) |=> busy [*4];
    endproperty
    a_disable_busy: assert property (p_disable_busy)
        else $error("busy dropped too soon after disable");

    property p_sw_pulls;
        @(posedge pclk) disable iff (!presetn)
        (en && control_q[CT_SW_PULL]) |-> pulls == control_q[7:4];
    endproperty
    a_sw_pulls: assert property (p_sw_pulls)
        else $error("pulls not under software control");

    property p_guard;
        @(posedge pclk) disable iff (!presetn)
        (!power_q[PW_GUARD]) |-> !sleep_block;
    endproperty
    a_guard: assert property (p_guard)
        else $error("sleep blocked without guard");

endmodule

//--- testbench/usb_line_partner.sv
`timescale 1ns/1ps
module usb_line_partner (
    // Clock and command from the bench
    input  wire logic       pclk,
    input  wire logic [6:0] cmd,
    // Cable and comparator levels
    output logic            id_pin,
    output logic            se0_level,
    output logic            j_level_indicator,
    output logic            session_cmp,
    output logic            b_end_cmp,
    output logic            a_valid_cmp,
    output logic            bus_activity
);
    // ==========================================================
    // Levels only move just after an edge
    initial begin
        {id_pin, se0_level, j_level_indicator, session_cmp} = 4'h8;
        {b_end_cmp, a_valid_cmp, bus_activity} = 3'h0;
        forever begin
            @(posedge pclk);
            {id_pin, se0_level, j_level_indicator, session_cmp, b_end_cmp, a_valid_cmp,
             bus_activity} <= cmd;
        end
    end
endmodule

//--- testbench/usb_otg_status_power_control_tb.sv
`timescale 1ns/1ps
module usb_otg_status_power_control_tb;
    import otg_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, seed, v;
    logic        id_pin, se0_level, j_level_indicator, session_cmp, b_end_cmp;
    logic        a_valid_cmp, bus_activity, module_active, activity_irq_taken;
    logic        supply_power_on, supply_charge_out, supply_discharge_out, sleep_block;
    logic        usb_clock_gate_n, xcvr_low_power, pins_owned, analog_enable, ls;
    pulls_s      hw_pulls, pulls;
    logic [6:0]  cmd;
    logic [32:0] exp_q[$];
    logic [32:0] exp_v;
    int          err_total, comparisons;

    usb_otg_status_power_control i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .id_pin, .se0_level, .j_level_indicator,
        .session_cmp, .b_end_cmp, .a_valid_cmp, .bus_activity, .hw_pulls, .module_active,
        .activity_irq_taken, .pulls, .supply_power_on, .supply_charge_out,
        .supply_discharge_out, .usb_clock_gate_n, .xcvr_low_power, .pins_owned,
        .analog_enable, .sleep_block);

    usb_line_partner i_partner (.pclk, .cmd, .id_pin, .se0_level, .j_level_indicator,
        .session_cmp, .b_end_cmp, .a_valid_cmp, .bus_activity);

    always #50 pclk = ~pclk;

    // ==========================================================
    // Helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    function automatic logic [31:0] st();
        return {24'h0, cmd[6], 1'b0, ls, 1'b0, cmd[3], cmd[2], 1'b0, cmd[1]};
    endfunction

    task automatic finish_test();
        $display("errors %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic fail(input string m);
        $display("wrong value at %0t: %s", $time, m);
        err_total++;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) fail($sformatf("output got %0h want %0h", g, e));
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // ==========================================================
    // APB master: expected read data goes on the queue first
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        int n;
        if (!w) exp_q.push_back(e);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (!pready && n < 20);
        if (!pready) begin
            fail("no ready");
            finish_test();
        end
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, {1'b0, e});
    endtask

    // ==========================================================
    // Read monitor
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) begin
            comparisons++;
            if (exp_q.size() == 0) begin
                fail("read with nothing expected");
            end else begin
                exp_v = exp_q.pop_front();
                if ({pslverr, prdata} !== exp_v) begin
                    fail($sformatf("read %0h got %0h want %0h", paddr, {pslverr, prdata}, exp_v));
                end
            end
        end
    end

    // ==========================================================
    // Main sequence
    initial begin
        pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00;
        pwdata = 32'h0; cmd = 7'h40; hw_pulls = '0; module_active = 0; ls = 0;
        activity_irq_taken = 0; seed = 32'hf73b; err_total = 0; comparisons = 0;
        cyc(2);
        presetn <= 1'b1;
        rd(ADDR_CONTROL, 32'h0);
        rd(ADDR_POWER, 32'h0);
        for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            cmd <= {seed[3], 2'b00, seed[2:0], 1'b0};
            cyc(4);
            rd(ADDR_STATUS, st());
        end
        wr(ADDR_STATUS, 32'hffff_ffff);
        rd(ADDR_STATUS, st());
        apb(1'b0, 8'h10, 32'h0, {1'b1, 32'h0});
        wr(ADDR_FLAGS, 32'hff);
        cmd <= cmd ^ 7'h08;
        cyc(4);
        rd(ADDR_FLAGS, 32'h08);
        wr(ADDR_FLAGS, 32'h08);
        rd(ADDR_FLAGS, 32'h0);
        seed = xs(seed);
        v = {24'hff_ffff, seed[7:0]};
        hw_pulls <= pulls_s'(seed[11:8]);
        wr(ADDR_CONTROL, v);
        rd(ADDR_CONTROL, {24'h0, v[7:0]});
        chk(32'({pulls, supply_power_on, supply_charge_out, supply_discharge_out,
                 pins_owned, analog_enable}), 32'h0);
        wr(ADDR_POWER, 32'h1);
        for (int k = 0; k < 2; k++) begin
            wr(ADDR_CONTROL, {24'h0, v[7:3], k[0], v[1:0]});
            chk(32'(pulls), k[0] ? 32'(v[7:4]) : 32'(hw_pulls));
            chk(32'({supply_power_on, supply_charge_out, supply_discharge_out}),
                32'({v[3], v[1:0]}));
        end
        chk(32'({pins_owned, analog_enable, usb_clock_gate_n, xcvr_low_power}),
            32'h0e);
        wr(ADDR_POWER, 32'hff);
        rd(ADDR_POWER, 32'h1b);
        chk(32'({usb_clock_gate_n, xcvr_low_power}), 32'h1);
        wr(ADDR_POWER, 32'h11);
        cmd[0] <= 1'b1;
        cyc(1);
        cmd[0] <= 1'b0;
        cyc(4);
        chk(32'(sleep_block), 32'h1);
        rd(ADDR_POWER, 32'h99);
        activity_irq_taken <= 1'b1;
        cyc(1);
        activity_irq_taken <= 1'b0;
        wr(ADDR_FLAGS, 32'hff);
        rd(ADDR_POWER, 32'h19);
        chk(32'(sleep_block), 32'h0);
        module_active <= 1'b1;
        wr(ADDR_POWER, 32'h0);
        rd(ADDR_POWER, 32'h08);
        module_active <= 1'b0;
        cyc(BUSY_CYCLES + 4);
        rd(ADDR_POWER, 32'h0);
        wr(ADDR_FLAGS, 32'hff);
        cmd[4] <= 1'b1;
        cyc(STABLE_CYCLES + 8);
        ls = 1'b1;
        rd(ADDR_STATUS, st());
        rd(ADDR_FLAGS, 32'h20);
        cmd[4] <= 1'b0;
        cyc(4);
        ls = 1'b0;
        rd(ADDR_STATUS, st());
        cyc(STABLE_CYCLES - 20);
        rd(ADDR_STATUS, st());
        finish_test();
    end
endmodule
